// File: pkg/pers_consts.vh
`ifndef PERS_CONSTS_VH
`define PERS_CONSTS_VH
`define PERS_OP_RESUME 8'hD0
`define PERS_OP_SUSPEND 8'hB0
`define PERS_OP_PROT_SEQ 8'h3D
`define PERS_OP_SECLOCK_RD 8'h35
`define PERS_OP_SECREG_RD 8'h77
`define PERS_OP_SECREG_PRG 8'h9B
`define PERS_OP_PROTREG_RD 8'h32
`define PERS_OP_XFER1 8'h53
`define PERS_OP_XFER2 8'h55
`define PERS_OP_CMP1 8'h60
`define PERS_OP_CMP2 8'h61
`define PERS_OP_DPD 8'hB9
`define PERS_OP_DPD_EXIT 8'hAB
`define PERS_OP_UDPD 8'h79
`define PERS_OP_STATUS_RD 8'hD7
`define PERS_OP_CFG_RD 8'h3F
`define PERS_OP_ID_RD 8'h9F
`define PERS_OP_RESET 8'hF0
`define PERS_CLK_MHZ 20
`define PERS_RES_LAT_NS 8000
`define PERS_RES_LAT_CYC ((`PERS_RES_LAT_NS * `PERS_CLK_MHZ + 999) / 1000)
`define PERS_KIND_NONE 2'h0
`define PERS_KIND_PRG1 2'h1
`define PERS_KIND_PRG2 2'h2
`define PERS_KIND_ERASE 2'h3
`endif

// File: core/pers_resume_ctrl.v
`timescale 1ns/1ns
`include "pers_consts.vh"
module pers_resume_ctrl (
  input wire ref_clk, // System clock, 20 MHz
  input wire rst, // Synchronous reset, active high
  input wire spi_sck, // Serial clock pin
  input wire spi_cs_n, // Chip select pin, active low
  input wire spi_mosi, // Serial data in pin
  input wire hw_reset_n, // Reset pin, active low
  input wire op_active_kind_valid, // Core starts an operation
  input wire [1:0] op_active_kind, // Kind of started operation
  input wire op_done, // Running operation has finished
  output reg first_buffer_program_suspended_flag, // Buffer 1 program suspended
  output reg second_buffer_program_suspended_flag, // Buffer 2 program suspended
  output reg erase_suspended_flag, // Erase suspended
  output wire ready, // Ready/busy flag, high when ready
  output reg resume_busy, // Resume latency window running
  output reg core_resume, // Pulse: continue operation where it stopped
  output reg core_suspend, // Pulse: freeze running operation
  output reg [1:0] core_kind, // Kind carried with core pulses
  output reg [7:0] cmd_opcode, // Last decoded opcode, accepted or refused
  output reg cmd_accept, // Pulse: opcode accepted
  output reg cmd_reject, // Pulse: opcode refused
  output reg soft_reset // Pulse: reset requested
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
// Every pin is asynchronous to ref_clk, so each one passes two flops
// before any logic looks at it; only the second stage is ever read,
// which keeps a metastable first stage away from the decode.
wire [3:0] pin_raw;
wire [3:0] pin_sync;
assign pin_raw = {hw_reset_n, spi_mosi, spi_cs_n, spi_sck};
genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : g_sync
    reg stage1;
    reg stage2;
    // Two-flop capture of one pin
    always @(posedge ref_clk) begin
      stage1 <= pin_raw[g];
      stage2 <= stage1;
    end
    assign pin_sync[g] = stage2;
  end
endgenerate

// Named views of the synchronised pins
wire sck_s2 = pin_sync[0];
wire cs_s2 = pin_sync[1];
wire di_s2 = pin_sync[2];
wire rstn_s2 = pin_sync[3];

// Serial clock edge finder; the host parks the clock low between
// frames, so a low delay stage never fakes a rise after reset
reg sck_d;
always @(posedge ref_clk) begin
  if (rst)
    sck_d <= 1'b0;
  else
    sck_d <= sck_s2;
end
wire sck_rise = sck_s2 & ~sck_d;

// Either reset source clears the shifter and the suspend state; the pin arrives two cycles late
wire any_rst = rst | ~rstn_s2;

////////////////////////////////////////////////////////////////////////
// Opcode shifter; only the first byte of a frame counts
// Bits beyond the eighth are left unshifted, so trailing address or
// data bytes never alter the opcode; a frame shorter than eight bits
// never sets op_valid and is dropped at chip select release.
reg [7:0] shift;
reg [3:0] bit_cnt;
reg [7:0] opcode;
reg op_valid;
reg cs_d;
wire frame_end = cs_s2 & ~cs_d;
always @(posedge ref_clk) begin
  if (any_rst) begin
    shift <= 8'h00;
    bit_cnt <= 4'h0;
    opcode <= 8'h00;
    op_valid <= 1'b0;
    cs_d <= 1'b1;
  end else begin
    cs_d <= cs_s2;
    if (cs_s2) begin
      bit_cnt <= 4'h0;
      if (frame_end)
        op_valid <= 1'b0;
    end else if (sck_rise && bit_cnt < 4'h8) begin
      shift <= {shift[6:0], di_s2};
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'h7) begin
        opcode <= {shift[6:0], di_s2}; // Later bytes ignored
        op_valid <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Command gating while suspended
// Decided from the opcode and the suspend flags; refusal only matters while a flag is
// set. Protection sequences share one first byte, so that byte stands
// for every protection and lockdown command.
wire any_susp = first_buffer_program_suspended_flag |
  second_buffer_program_suspended_flag | erase_suspended_flag;
reg allowed;
always @* begin
  allowed = 1'b1;
  if (any_susp) begin
    case (opcode)
      `PERS_OP_PROT_SEQ, `PERS_OP_SECREG_PRG: allowed = 1'b0;
      `PERS_OP_DPD, `PERS_OP_DPD_EXIT, `PERS_OP_UDPD: allowed = 1'b0;
      `PERS_OP_XFER1: allowed = ~first_buffer_program_suspended_flag;
      `PERS_OP_XFER2: allowed = ~second_buffer_program_suspended_flag;
      `PERS_OP_CMP1, `PERS_OP_CMP2: allowed = 1'b1;
      `PERS_OP_PROTREG_RD, `PERS_OP_SECLOCK_RD, `PERS_OP_SECREG_RD:
        allowed = 1'b1;
      `PERS_OP_STATUS_RD, `PERS_OP_CFG_RD, `PERS_OP_ID_RD: allowed = 1'b1;
      `PERS_OP_RESET: allowed = 1'b1;
      default: allowed = 1'b1;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Suspend/resume state
// Flags are set only by a suspend and cleared by a resume or reset.
// Resume latency in ref_clk cycles; the counter is 16 bits wide, so
// the integer figure is cut to that width on purpose
localparam integer RES_LAT_INT = `PERS_RES_LAT_CYC;
localparam [15:0] RES_LAT = RES_LAT_INT[15:0];
reg [1:0] running; // Kind of operation in progress
reg [15:0] res_cnt;
wire do_cmd = frame_end & op_valid;
always @(posedge ref_clk) begin
  if (any_rst) begin // Reset aborts any suspend
    first_buffer_program_suspended_flag <= 1'b0;
    second_buffer_program_suspended_flag <= 1'b0;
    erase_suspended_flag <= 1'b0;
    running <= `PERS_KIND_NONE;
    res_cnt <= 16'h0000;
    resume_busy <= 1'b0;
    core_resume <= 1'b0;
    core_suspend <= 1'b0;
    core_kind <= `PERS_KIND_NONE;
    cmd_opcode <= 8'h00;
    cmd_accept <= 1'b0;
    cmd_reject <= 1'b0;
    soft_reset <= 1'b0;
  end else begin
    // Pulses last one cycle unless set again below; this keeps
    // a downstream core from seeing one command twice
    core_resume <= 1'b0;
    core_suspend <= 1'b0;
    cmd_accept <= 1'b0;
    cmd_reject <= 1'b0;
    soft_reset <= 1'b0;
    // Count the latency down; busy drops on the last count, so the
    // window is exactly the loaded number of cycles long
    if (resume_busy) begin
      if (res_cnt == 16'h0001)
        resume_busy <= 1'b0; // Resume latency bound
      res_cnt <= res_cnt - 16'h0001;
    end
    if (op_done)
      running <= `PERS_KIND_NONE;
    else if (op_active_kind_valid)
      running <= op_active_kind;
    if (do_cmd) begin // Acts only at chip select release
      cmd_opcode <= opcode;
      cmd_accept <= allowed;
      cmd_reject <= ~allowed;
      soft_reset <= allowed & (opcode == `PERS_OP_RESET);
      // Program flags are looked at before erase, so a stacked
      // suspend always reopens the program first
      if (opcode == `PERS_OP_RESUME) begin
        if (first_buffer_program_suspended_flag |
            second_buffer_program_suspended_flag) begin // Program first
          first_buffer_program_suspended_flag <= 1'b0;
          second_buffer_program_suspended_flag <= 1'b0;
          running <= first_buffer_program_suspended_flag ?
            `PERS_KIND_PRG1 : `PERS_KIND_PRG2; // Busy again
          core_kind <= first_buffer_program_suspended_flag ?
            `PERS_KIND_PRG1 : `PERS_KIND_PRG2;
          core_resume <= 1'b1; // Continue, not restart
          resume_busy <= 1'b1;
          res_cnt <= RES_LAT;
        end else if (erase_suspended_flag) begin
          erase_suspended_flag <= 1'b0;
          running <= `PERS_KIND_ERASE;
          core_kind <= `PERS_KIND_ERASE;
          core_resume <= 1'b1;
          resume_busy <= 1'b1;
          res_cnt <= RES_LAT;
        end // Nothing suspended: no-op
        // A suspend is ignored while the resume window runs, so the
        // host must wait or poll before pausing again
      end else if (opcode == `PERS_OP_SUSPEND && !resume_busy &&
                   running != `PERS_KIND_NONE) begin // Ignored mid-resume
        core_suspend <= 1'b1;
        core_kind <= running;
        running <= `PERS_KIND_NONE; // Shows ready
        case (running) // Erase flag may coexist
          `PERS_KIND_PRG1: first_buffer_program_suspended_flag <= 1'b1;
          `PERS_KIND_PRG2: second_buffer_program_suspended_flag <= 1'b1;
          `PERS_KIND_ERASE: erase_suspended_flag <= 1'b1;
          default: erase_suspended_flag <= erase_suspended_flag;
        endcase
      end
    end
  end
end

// Busy while an operation runs or resume settles
// Combinational so the flag follows the state in the same cycle,
// with no extra cycle of stale ready after a resume
assign ready = (running == `PERS_KIND_NONE) & ~resume_busy;

endmodule

// File: test/pers_host.sv
`timescale 1ns/1ns
module pers_host (
  output reg sck, // Serial clock, idle low
  output reg cs_n, // Chip select, active low
  output reg mosi // Serial data to the device
);
  integer i;
  ////////////////////////////////////////
  // Idle bus: clock parked low, device not selected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame, MSB first, mode 0; released data line shows the inverse
  task send(input [15:0] d, input integer nb);
    begin
      cs_n = 1'b0;
      for (i = nb - 1; i >= 0; i = i - 1) begin
        mosi = d[i];
        #200 sck = 1'b1;
        #200 sck = 1'b0;
      end
      #200 cs_n = 1'b1;
      mosi = ~mosi;
      #2000;
    end
  endtask
endmodule

// File: test/pers_resume_assertions.sv
`timescale 1ns/1ns
`include "pers_consts.vh"
module pers_resume_chk (
  input wire ref_clk, // System clock
  input wire rst, // Sync reset
  input wire first_buffer_program_suspended_flag, // Buffer 1 suspended
  input wire second_buffer_program_suspended_flag, // Buffer 2 suspended
  input wire erase_suspended_flag, // Erase suspended
  input wire ready, // High when ready
  input wire resume_busy, // Resume window
  input wire core_resume, // Resume pulse
  input wire core_suspend, // Suspend pulse
  input wire [1:0] core_kind, // Kind with pulses
  input wire [7:0] cmd_opcode, // Last opcode, accepted or refused
  input wire cmd_accept, // Accept pulse
  input wire cmd_reject, // Refuse pulse
  input wire soft_reset // Reset request pulse
);
  localparam int LAT = `PERS_RES_LAT_CYC;
  wire s1 = first_buffer_program_suspended_flag;
  wire s2 = second_buffer_program_suspended_flag;
  wire se = erase_suspended_flag;
  wire any = s1 | s2 | se;
  reg [9:0] cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Length of the resume window, exact figure checked at its end
  always @(posedge ref_clk) begin
    cnt <= (resume_busy && !rst) ? cnt + 10'h001 : 10'h000;
  end
  // Command effects and gating
  AST_RES_CLEARS: assert property (core_resume |-> ##[0:2]
    !(core_kind == `PERS_KIND_PRG1 ? s1 : core_kind == `PERS_KIND_PRG2 ? s2 : se))
    else $error("suspend flag not cleared by resume");
  AST_RES_BUSY: assert property (core_resume |-> ##[0:2] !ready)
    else $error("ready high after resume");
  AST_RES_LAT: assert property ($fell(resume_busy) |-> cnt == LAT)
    else $error("resume window length wrong");
  AST_SUSP_IGN: assert property (resume_busy && $past(resume_busy) |-> !core_suspend)
    else $error("suspend taken during resume");
  AST_SUSP_SETS: assert property (core_suspend |-> ##[0:2] (ready && any))
    else $error("suspend did not set flag and ready");
  AST_NOOP: assert property (core_resume |-> $past(any))
    else $error("resume with nothing suspended");
  AST_PRG_FIRST: assert property (core_resume && $past(se) && $past(s1 | s2)
    |-> core_kind != `PERS_KIND_ERASE && se) else $error("erase resumed before program");
  AST_GATE_LOCK: assert property (cmd_accept && any
    |-> !(cmd_opcode inside {8'h3D, 8'h9B, 8'hB9, 8'hAB, 8'h79}))
    else $error("refused command accepted in suspend");
  AST_GATE_XFER: assert property (cmd_accept
    |-> !(cmd_opcode == 8'h53 && s1) && !(cmd_opcode == 8'h55 && s2))
    else $error("transfer into suspended buffer accepted");
  AST_ONE_VERDICT: assert property (!(cmd_accept && cmd_reject))
    else $error("command both accepted and refused");
  AST_SOFT_RST: assert property (soft_reset ==
    (cmd_accept && cmd_opcode == `PERS_OP_RESET)) else $error("reset request mismatch");
  cover property (core_resume && se);
  cover property (cmd_accept && cmd_opcode == 8'h53);
  cover property ($fell(resume_busy));
endmodule
bind pers_resume_ctrl pers_resume_chk chk (.ref_clk, .rst, .first_buffer_program_suspended_flag,
  .second_buffer_program_suspended_flag, .erase_suspended_flag, .ready, .resume_busy,
  .core_resume, .core_suspend, .core_kind, .cmd_opcode, .cmd_accept, .cmd_reject, .soft_reset);

// File: test/tb_pers_resume_ctrl.sv
`timescale 1ns/1ns
module tb_pers_resume_ctrl;
  localparam [127:0] OPS = 128'h3D9B_3235_7753_5560_61B9_AB79_D73F_9FF0;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg hw_reset_n = 1'b1;
  reg op_active_kind_valid = 1'b0;
  reg [1:0] op_active_kind = 2'h0;
  reg op_done = 1'b0;
  wire spi_sck, spi_cs_n, spi_mosi, f1, f2, fe, ready, resume_busy, cmd_accept, cmd_reject;
  reg [1:0] res = 2'h0;
  reg e1 = 1'b0, e2 = 1'b0, ee = 1'b0, er = 1'b1;
  integer errors = 0, checked = 0, i;
  pers_host host (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi));
  pers_resume_ctrl uut (.ref_clk(ref_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .hw_reset_n(hw_reset_n), .op_active_kind_valid(op_active_kind_valid),
    .op_active_kind(op_active_kind), .op_done(op_done),
    .first_buffer_program_suspended_flag(f1), .second_buffer_program_suspended_flag(f2),
    .erase_suspended_flag(fe), .ready(ready), .resume_busy(resume_busy), .core_resume(),
    .core_suspend(), .core_kind(), .cmd_opcode(), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .soft_reset());
  ////////////////////////////////////////
  // Clock and the verdict of the last command
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // Verdict cleared while a frame is open, so a missing pulse shows as 0
  always @(posedge ref_clk) begin
    if (cmd_accept || cmd_reject)
      res <= {cmd_accept, cmd_reject};
    else if (!spi_cs_n)
      res <= 2'h0;
  end
  task ck(input [7:0] s, input [7:0] e, input [47:0] n);
    begin
      checked = checked + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task st(input [47:0] n);
    ck({4'h0, f1, f2, fe, ready}, {4'h0, e1, e2, ee, er}, n);
  endtask
  // Core start (d=0) or finish (d=1) pulse
  task op(input d, input [1:0] k);
    begin
      @(posedge ref_clk);
      op_done <= d;
      op_active_kind_valid <= !d;
      op_active_kind <= k;
      @(posedge ref_clk);
      op_done <= 1'b0;
      op_active_kind_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      er = d;
    end
  endtask
  task cmd(input [15:0] d, input integer nb);
    begin
      host.send(d, nb);
    end
  endtask
  function ok(input [7:0] o);
    case (o)
      8'h3D, 8'h9B, 8'hB9, 8'hAB, 8'h79: ok = 1'b0;
      8'h53: ok = !e1;
      8'h55: ok = !e2;
      default: ok = 1'b1;
    endcase
  endfunction
  task gate(input integer n);
    for (i = 0; i < n; i = i + 1) begin
      cmd({8'h00, OPS[8*(15-i) +: 8]}, 8);
      ck({6'h00, res}, {6'h00, ok(OPS[8*(15-i) +: 8]), !ok(OPS[8*(15-i) +: 8])}, "gate");
    end
  endtask
  // Waits out the resume window before any new suspend
  task lat;
    begin
      for (i = 0; i < 500 && resume_busy === 1'b1; i = i + 1) @(posedge ref_clk);
      ck({7'h00, resume_busy}, 8'h00, "lat");
    end
  endtask
  task close_out;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Bounded run: a hang counts as a mismatch
  initial begin
    #1500000;
    errors = errors + 1;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    st("reset");
    op(1'b0, 2'h1);
    cmd(16'h00B0, 8);
    e1 = 1'b1;
    er = 1'b1;
    st("susp1");
    gate(15);
    cmd(16'hD053, 16);
    e1 = 1'b0;
    er = 1'b0;
    st("res1");
    ck({7'h00, resume_busy}, 8'h01, "busy");
    cmd(16'h00B0, 8);
    st("ign");
    lat;
    op(1'b1, 2'h0);
    st("done1");
    $display("test single suspend done");
    op(1'b0, 2'h3);
    cmd(16'h00B0, 8);
    ee = 1'b1;
    er = 1'b1;
    op(1'b0, 2'h2);
    cmd(16'h00B0, 8);
    e2 = 1'b1;
    er = 1'b1;
    st("both");
    gate(15);
    cmd(16'h00D0, 8);
    e2 = 1'b0;
    er = 1'b0;
    st("prg1st");
    lat;
    op(1'b1, 2'h0);
    cmd(16'h00D0, 8);
    ee = 1'b0;
    er = 1'b0;
    st("erase");
    lat;
    op(1'b1, 2'h0);
    cmd(16'h00D0, 8);
    st("noop");
    $display("test double suspend done");
    op(1'b0, 2'h2);
    cmd(16'h00B0, 8);
    e2 = 1'b1;
    er = 1'b1;
    gate(16);
    @(posedge ref_clk);
    hw_reset_n <= 1'b0;
    @(posedge ref_clk);
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    e2 = 1'b0;
    st("hwrst");
    $display("test reset in suspend done");
    close_out;
  end
endmodule
